// ### verilog/tpo_pkg.sv
package tpo_pkg;

    // ------------------------------------------------------------------
    // Sizes of the pattern unit
    // ------------------------------------------------------------------
    localparam int TPO_NPINS = 16;
    localparam int TPO_NGROUPS = 4;
    localparam int TPO_NCHAN = 4;
    localparam int TPO_ADDR_W = 12;

    // ------------------------------------------------------------------
    // Register byte offsets on the APB slave
    // ------------------------------------------------------------------
    localparam logic [11:0] TPO_OFF_DIR_A = 12'h000;
    localparam logic [11:0] TPO_OFF_DIR_B = 12'h004;
    localparam logic [11:0] TPO_OFF_OUT_A = 12'h008;
    localparam logic [11:0] TPO_OFF_OUT_B = 12'h00c;
    localparam logic [11:0] TPO_OFF_NDE_A = 12'h010;
    localparam logic [11:0] TPO_OFF_NDE_B = 12'h014;
    localparam logic [11:0] TPO_OFF_NXT_A = 12'h018;
    localparam logic [11:0] TPO_OFF_NXT_B = 12'h01c;
    localparam logic [11:0] TPO_OFF_TRIG = 12'h020;
    localparam logic [11:0] TPO_OFF_MODE = 12'h024;

    // ------------------------------------------------------------------
    // Values after reset and fixed fields
    // ------------------------------------------------------------------
    localparam logic [7:0] TPO_RST_BYTE = 8'h00;
    localparam logic [7:0] TPO_RST_TRIG = 8'hff;
    localparam logic [3:0] TPO_RST_MODE = 4'h0;
    localparam logic [3:0] TPO_MODE_RSVD = 4'hf;
    localparam int TPO_MODE_RSVD_POS = 4;
    localparam int TPO_SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // Event bundle from the timer unit, one bit per channel
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cmp_a;
        logic [3:0] cmp_b;
        logic [3:0] cap_a;
        logic [3:0] gra_capture;
    } tpo_timer_evt_t;

    // Picks the event of the channel named by a two-bit select.
    function automatic logic tpo_chan_pick(input logic [3:0] evt, input logic [1:0] sel);
        tpo_chan_pick = evt[sel];
    endfunction

    // Value seen by software when reading a port byte.
    function automatic logic [7:0] tpo_port_view(input logic [7:0] dir, input logic [7:0] dr,
                                                 input logic [7:0] pin);
        tpo_port_view = (dir & dr) | (~dir & pin);
    endfunction

endpackage

// ### verilog/tpo_sync.sv
module tpo_sync
    import tpo_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ------------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------------

    logic [W-1:0] stage1;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= '0;
            q <= '0;
        end
        else if (ce)
        begin
            stage1 <= d;
            q <= stage1;
        end
    end

endmodule

// ### verilog/tpo_group.sv
module tpo_group
    import tpo_pkg::*;
(
    input wire logic overlap_free,
    input wire logic trig_a,
    input wire logic trig_b,
    input wire logic [3:0] next_bits,
    output logic [3:0] load,
    output logic [3:0] load_val
);

    // ------------------------------------------------------------------
    // Transfer decision for one group of four outputs
    // ------------------------------------------------------------------

    // The A trigger always moves every bit; in the overlap-free mode compare B
    // moves only the zero bits, so falling edges lead rising ones.
    wire all_move = trig_a;
    wire zero_move = overlap_free & trig_b & ~trig_a;

    // Normal mode reacts to A only; the overlap-free mode uses A and B.
    assign load = all_move ? 4'hf : (zero_move ? ~next_bits : 4'h0);
    // B transfers zeros only; ones wait for A.
    assign load_val = next_bits;

endmodule

// ### verilog/tpo_top.sv
module tpo_top
    import tpo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tpo_timer_evt_t timer_evt,
    input wire logic [15:0] timer_pin_oe,
    input wire logic [15:0] timer_pin_val,
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe,
    output logic [15:0] pattern_active
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------

    logic [15:0] port_direction;
    logic [15:0] next_data_enable;
    logic [15:0] port_output_value;
    logic [15:0] next_pattern;
    logic [7:0] trigger_channel_select;
    logic [3:0] overlap_free_sel;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [15:0] next_port_output_value;
    logic [15:0] pin_sync;

    // Named views of the overlap-free selects per group.
    wire group0_overlap_free_sel = overlap_free_sel[0];
    wire group1_overlap_free_sel = overlap_free_sel[1];
    wire group2_overlap_free_sel = overlap_free_sel[2];
    wire group3_overlap_free_sel = overlap_free_sel[3];

    // The four selects again as one vector, one bit per group.
    wire [3:0] grp_mode = {group3_overlap_free_sel, group2_overlap_free_sel,
                           group1_overlap_free_sel, group0_overlap_free_sel};

    // ------------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------------

    // Pins come from outside the clock domain and are read only after two flops.
    tpo_sync #(.W(TPO_NPINS)) u_pin_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(pin_in),
        .q(pin_sync)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------

    // The slave never inserts wait states while enabled.
    assign pready = ce;

    // A setup cycle latches read data; an access cycle commits a write.
    wire apb_setup = ce & psel & ~penable;
    wire apb_write = ce & psel & penable & pwrite & pstrb[0];

    // Address hits for each register.
    wire hit_dir_a = (paddr == TPO_OFF_DIR_A);
    wire hit_dir_b = (paddr == TPO_OFF_DIR_B);
    wire hit_out_a = (paddr == TPO_OFF_OUT_A);
    wire hit_out_b = (paddr == TPO_OFF_OUT_B);
    wire hit_nde_a = (paddr == TPO_OFF_NDE_A);
    wire hit_nde_b = (paddr == TPO_OFF_NDE_B);
    wire hit_nxt_a = (paddr == TPO_OFF_NXT_A);
    wire hit_nxt_b = (paddr == TPO_OFF_NXT_B);
    wire hit_trig = (paddr == TPO_OFF_TRIG);
    wire hit_mode = (paddr == TPO_OFF_MODE);
    wire hit_any = hit_dir_a | hit_dir_b | hit_out_a | hit_out_b | hit_nde_a | hit_nde_b
                 | hit_nxt_a | hit_nxt_b | hit_trig | hit_mode;

    // Byte-wide write data in the low lane.
    wire [7:0] wbyte = pwdata[7:0];

    // ------------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------------

    // Register A in capture mode turns the capture event into the A trigger.
    wire [3:0] chan_evt_a = (timer_evt.gra_capture & timer_evt.cap_a)
                          | (~timer_evt.gra_capture & timer_evt.cmp_a);

    // Compare B marks the period and A the margin in the overlap-free mode.
    wire [3:0] chan_evt_b = timer_evt.cmp_b;

    logic [3:0] grp_trig_a;
    logic [3:0] grp_trig_b;
    logic [15:0] hw_load;
    logic [15:0] hw_val;

    // Each group picks its channel and decides which bits it moves.
    for (genvar g = 0; g < TPO_NGROUPS; g++)
    begin : g_grp
        // Two select bits per group choose channel 0 to 3.
        wire [1:0] grp_sel = trigger_channel_select[2*g+1:2*g];
        assign grp_trig_a[g] = tpo_chan_pick(chan_evt_a, grp_sel);
        assign grp_trig_b[g] = tpo_chan_pick(chan_evt_b, grp_sel);

        tpo_group u_group
        (
            .overlap_free(grp_mode[g]),
            .trig_a(grp_trig_a[g]),
            .trig_b(grp_trig_b[g]),
            .next_bits(next_pattern[4*g+3:4*g]),
            .load(hw_load[4*g+3:4*g]),
            .load_val(hw_val[4*g+3:4*g])
        );
    end

    // ------------------------------------------------------------------
    // Output data register update
    // ------------------------------------------------------------------

    // Bits with enable set and direction clear are read-only for software.
    wire [15:0] sw_protect = next_data_enable & ~port_direction;

    // Software write strobes per bit of the output data register.
    wire wr_out_a = apb_write & hit_out_a;
    wire wr_out_b = apb_write & hit_out_b;
    wire [15:0] sw_wr = {{8{wr_out_b}}, {8{wr_out_a}}} & ~sw_protect;

    // A trigger copy wins over a software write in the same cycle; the copy
    // runs whatever the pin function, so input pins still collect pattern data.
    always_comb
    begin
        next_port_output_value = port_output_value;
        for (int i = 0; i < TPO_NPINS; i++)
        begin
            if (sw_wr[i])
            begin
                next_port_output_value[i] = pwdata[i % 8];
            end
            if (hw_load[i])
            begin
                next_port_output_value[i] = hw_val[i];
            end
        end
    end

    // Data register, loaded in the same edge as the trigger.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_output_value <= {TPO_RST_BYTE, TPO_RST_BYTE};
        end
        else if (ce)
        begin
            port_output_value <= next_port_output_value;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // Direction bytes; a set bit makes the pin an output.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_direction <= {TPO_RST_BYTE, TPO_RST_BYTE};
        end
        else if (apb_write)
        begin
            if (hit_dir_a)
            begin
                port_direction[7:0] <= wbyte;
            end
            if (hit_dir_b)
            begin
                port_direction[15:8] <= wbyte;
            end
        end
    end

    // Next-data enable bytes; a set bit marks a pattern pin and, with direction clear, blocks software writes to the data bit.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            next_data_enable <= {TPO_RST_BYTE, TPO_RST_BYTE};
        end
        else if (apb_write)
        begin
            if (hit_nde_a)
            begin
                next_data_enable[7:0] <= wbyte;
            end
            if (hit_nde_b)
            begin
                next_data_enable[15:8] <= wbyte;
            end
        end
    end

    // Next pattern bytes, refilled by software between triggers.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            next_pattern <= {TPO_RST_BYTE, TPO_RST_BYTE};
        end
        else if (apb_write)
        begin
            if (hit_nxt_a)
            begin
                next_pattern[7:0] <= wbyte;
            end
            if (hit_nxt_b)
            begin
                next_pattern[15:8] <= wbyte;
            end
        end
    end

    // Trigger channel selects; every group starts on channel 3.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trigger_channel_select <= TPO_RST_TRIG;
        end
        else if (apb_write & hit_trig)
        begin
            trigger_channel_select <= wbyte;
        end
    end

    // Overlap-free selects; every group starts in normal mode.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overlap_free_sel <= TPO_RST_MODE;
        end
        else if (apb_write & hit_mode)
        begin
            overlap_free_sel <= wbyte[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Selects the read value; input bits show the synchronised pins.
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (1'b1)
            hit_dir_a: next_prdata[7:0] = port_direction[7:0];
            hit_dir_b: next_prdata[7:0] = port_direction[15:8];
            hit_out_a: next_prdata[7:0] = tpo_port_view(port_direction[7:0],
                                                        port_output_value[7:0], pin_sync[7:0]);
            hit_out_b: next_prdata[7:0] = tpo_port_view(port_direction[15:8],
                                                        port_output_value[15:8], pin_sync[15:8]);
            hit_nde_a: next_prdata[7:0] = next_data_enable[7:0];
            hit_nde_b: next_prdata[7:0] = next_data_enable[15:8];
            hit_nxt_a: next_prdata[7:0] = next_pattern[7:0];
            hit_nxt_b: next_prdata[7:0] = next_pattern[15:8];
            hit_trig: next_prdata[7:0] = trigger_channel_select;
            hit_mode: next_prdata[7:0] = {TPO_MODE_RSVD, overlap_free_sel};
            default: next_pslverr = ~hit_any;
        endcase
    end

    // Read data are captured in the setup cycle and held for the access cycle.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (apb_setup)
        begin
            prdata <= next_prdata;
        end
    end

    // The error flag is captured with the read data, so both stand together.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pslverr <= 1'b0;
        end
        else if (apb_setup)
        begin
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------

    // Pattern output needs both the direction and the next-data enable bit.
    assign pattern_active = port_direction & next_data_enable & ~timer_pin_oe;

    // The pin shows the data register, so it starts from its current value;
    // a timer output on the shared pin takes the pin over.
    assign pin_out = (timer_pin_oe & timer_pin_val)
                   | (~timer_pin_oe & port_output_value);

    // Direction alone makes a plain output; enable without direction stays an input.
    assign pin_oe = timer_pin_oe | port_direction;

endmodule

// ### verif/tpo_timer_model.sv
module tpo_timer_model
    import tpo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    output tpo_timer_evt_t timer_evt,
    output logic [15:0] timer_pin_oe,
    output logic [15:0] timer_pin_val
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Timer event source
    // ------------------------------------------------------------------
    // The timer starts silent and drives no pin.
    initial
    begin
        timer_evt = '0;
        timer_pin_oe = 16'h0000;
        timer_pin_val = 16'h0000;
    end

    // One-cycle pulse: kind 0 compare A, 1 compare B, 2 capture, 3 both compares.
    // Returns at the falling edge after the edge that saw the pulse.
    task automatic fire(input int kind, input int ch);
        @(posedge clk);
        timer_evt.cmp_a <= (kind == 0 || kind == 3) ? 4'h1 << ch : 4'h0;
        timer_evt.cmp_b <= (kind == 1 || kind == 3) ? 4'h1 << ch : 4'h0;
        timer_evt.cap_a <= (kind == 2) ? 4'h1 << ch : 4'h0;
        @(posedge clk);
        timer_evt.cmp_a <= 4'h0;
        timer_evt.cmp_b <= 4'h0;
        timer_evt.cap_a <= 4'h0;
        @(negedge clk);
    endtask

    // Marks which channels run register A as a capture register.
    task automatic set_capture(input logic [3:0] m);
        @(posedge clk);
        timer_evt.gra_capture <= m;
    endtask

    // Hands pins over to the timer's own output function.
    task automatic set_pins(input logic [15:0] oe, input logic [15:0] val);
        @(posedge clk);
        timer_pin_oe <= oe;
        timer_pin_val <= val;
        @(negedge clk);
    endtask
endmodule

// ### verif/tpo_top_sva.sv
module tpo_top_sva
    import tpo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tpo_timer_evt_t timer_evt,
    input wire logic [15:0] timer_pin_oe,
    input wire logic [15:0] timer_pin_val,
    input wire logic [15:0] pin_in,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pattern_active
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Mode shadow and step sequences
    // ------------------------------------------------------------------
    logic [3:0] mode_q;
    logic [15:0] nov_mask;
    logic wr_acc;
    logic a_evt;

    // Decodes the bus write and the copy causes.
    assign wr_acc = psel && penable && pwrite && ce;
    assign a_evt = |{timer_evt.cmp_a, timer_evt.cap_a};
    assign nov_mask = {{4{mode_q[3]}}, {4{mode_q[2]}}, {4{mode_q[1]}}, {4{mode_q[0]}}};

    // Shadows the overlap-free select bits as software writes them.
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            mode_q <= 4'h0;
        else if (wr_acc && pstrb[0] && paddr == TPO_OFF_MODE)
            mode_q <= pwdata[3:0];

    sequence quiet_s;
        (!wr_acc && !a_evt && !(|timer_evt.cmp_b))
        ##1 ($stable(timer_pin_oe) && $stable(timer_pin_val));
    endsequence

    sequence only_b_s;
        (!wr_acc && !a_evt && |timer_evt.cmp_b)
        ##1 ($stable(timer_pin_oe) && $stable(timer_pin_val));
    endsequence

    quiet_hold_a: assert property (quiet_s |-> $stable(pin_out))
        else $error("pin output moved with no cause");
    b_no_rise_a: assert property (only_b_s |-> (pin_out & ~$past(pin_out)) == 16'h0)
        else $error("compare B raised an output bit");
    normal_b_a: assert property (
        only_b_s |-> ((pin_out ^ $past(pin_out)) & ~nov_mask) == 16'h0)
        else $error("normal group moved on compare B");
    quiet_active_a: assert property (
        !wr_acc ##1 $stable(timer_pin_oe) |-> $stable(pattern_active))
        else $error("pin function changed with no write");
    active_drive_a: assert property ((pattern_active & ~pin_oe) == 16'h0)
        else $error("pattern pin not driven");
    timer_owns_a: assert property (
        ((pin_out ^ timer_pin_val) & timer_pin_oe) == 16'h0 && (timer_pin_oe & ~pin_oe) == 16'h0)
        else $error("timer pin not carrying timer value");
    timer_excl_a: assert property ((pattern_active & timer_pin_oe) == 16'h0)
        else $error("pattern active on timer pin");
    unmapped_err_a: assert property (
        psel && penable && ce && paddr > TPO_OFF_MODE |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    ready_ce_a: assert property (pready == ce)
        else $error("ready does not follow clock enable");
endmodule

bind tpo_top tpo_top_sva tpo_top_sva_i (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_evt(timer_evt),
    .timer_pin_oe(timer_pin_oe), .timer_pin_val(timer_pin_val), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pattern_active(pattern_active));

// ### verif/testbench.sv
module testbench
    import tpo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic [15:0] timer_pin_oe, timer_pin_val, pin_in, pin_out, pin_oe, pattern_active;
    tpo_timer_evt_t timer_evt;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] prev, nxt;

    tpo_top tpo_top_i (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_evt(timer_evt),
        .timer_pin_oe(timer_pin_oe), .timer_pin_val(timer_pin_val), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pattern_active(pattern_active));
    tpo_timer_model timer_i (.clk(clk), .rst_n(rst_n), .timer_evt(timer_evt),
        .timer_pin_oe(timer_pin_oe), .timer_pin_val(timer_pin_val));

    // ------------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------------
    // The clock toggles every half period of 4 ns.
    always #4 clk = ~clk;

    // Cuts the run short if a wait never ends.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values, the reserved mode bits and an unmapped address.
    task automatic t_regs();
        logic [11:0] offs [5] = '{TPO_OFF_DIR_A, TPO_OFF_DIR_B, TPO_OFF_NDE_A, TPO_OFF_NXT_A,
                                  TPO_OFF_OUT_A};
        foreach (offs[i])
        begin
            apb(1'b0, offs[i], 8'h00);
            check(rdat[7:0], TPO_RST_BYTE);
        end
        apb(1'b0, TPO_OFF_TRIG, 8'h00);
        check(rdat[7:0], TPO_RST_TRIG);
        apb(1'b0, TPO_OFF_MODE, 8'h00);
        check(rdat[7:0], 8'hf0);
        apb(1'b1, TPO_OFF_MODE, 8'h0a);
        apb(1'b0, TPO_OFF_MODE, 8'h00);
        check(rdat[7:0], 8'hfa);
        apb(1'b1, TPO_OFF_MODE, 8'h00);
        apb(1'b0, 12'h040, 8'h00);
        check({7'h0, rerr}, 8'h01);
        check(rdat[7:0], 8'h00);
        $display("test regs done");
    endtask

    // Normal mode on every channel select code.
    task automatic t_normal();
        apb(1'b1, TPO_OFF_DIR_A, 8'hff);
        apb(1'b1, TPO_OFF_OUT_A, 8'h3c);
        apb(1'b1, TPO_OFF_NDE_A, 8'hff);
        check(pin_out[7:0], 8'h3c);
        check(pattern_active[7:0], 8'hff);
        prev = 8'h3c;
        for (int c = 0; c < 4; c++)
        begin
            nxt = {4'(c * 3 + 1), 4'(c * 5 + 3)};
            apb(1'b1, TPO_OFF_TRIG, {4'hf, 2'(c), 2'(c)});
            apb(1'b1, TPO_OFF_NXT_A, nxt);
            timer_i.fire(0, (c + 1) % 4);
            timer_i.fire(1, c);
            check(pin_out[7:0], prev);
            timer_i.fire(0, c);
            check(pin_out[7:0], nxt);
            prev = nxt;
        end
        $display("test normal done");
    endtask

    // Overlap-free group 0, group 1 left normal.
    task automatic t_nonover();
        apb(1'b1, TPO_OFF_MODE, 8'h01);
        apb(1'b1, TPO_OFF_TRIG, 8'hfd);
        apb(1'b1, TPO_OFF_OUT_A, 8'h9c);
        apb(1'b1, TPO_OFF_NXT_A, 8'h56);
        timer_i.fire(1, 1);
        check(pin_out[7:0], 8'h94);
        timer_i.fire(0, 1);
        check(pin_out[7:0], 8'h96);
        apb(1'b1, TPO_OFF_NXT_A, 8'h59);
        timer_i.fire(3, 1);
        check(pin_out[7:0], 8'h99);
        $display("test overlap free done");
    endtask

    // Capture trigger, timer-owned pin, and an enabled input pin.
    task automatic t_pins();
        timer_i.set_capture(4'h2);
        apb(1'b1, TPO_OFF_NXT_A, 8'h5a);
        timer_i.fire(0, 1);
        check(pin_out[7:0], 8'h99);
        timer_i.fire(2, 1);
        check(pin_out[7:0], 8'h9a);
        timer_i.set_capture(4'h0);
        timer_i.set_pins(16'h0004, 16'h0004);
        check(pin_out[7:0], 8'h9e);
        check(pattern_active[7:0], 8'hfb);
        apb(1'b1, TPO_OFF_NXT_A, 8'h00);
        timer_i.fire(0, 1);
        timer_i.set_pins(16'h0000, 16'h0000);
        check(pin_out[7:0], 8'h90);
        apb(1'b1, TPO_OFF_DIR_A, 8'h7f);
        check(pin_oe[7:0], 8'h7f);
        apb(1'b1, TPO_OFF_OUT_A, 8'h00);
        check(pin_out[7:0], 8'h80);
        @(posedge clk);
        pin_in <= 16'h0080;
        repeat (2) @(posedge clk);
        apb(1'b0, TPO_OFF_OUT_A, 8'h00);
        check(rdat[7:0], 8'h80);
        timer_i.fire(0, 3);
        apb(1'b1, TPO_OFF_DIR_A, 8'hff);
        check(pin_out[7:0], 8'h00);
        $display("test pins done");
    endtask

    // Port B groups overlap-free on two channels, then a frozen clock enable.
    task automatic t_portb();
        apb(1'b1, TPO_OFF_DIR_B, 8'hff);
        apb(1'b1, TPO_OFF_NDE_B, 8'hff);
        apb(1'b1, TPO_OFF_OUT_B, 8'h5a);
        apb(1'b1, TPO_OFF_NXT_B, 8'h3c);
        apb(1'b1, TPO_OFF_MODE, 8'h0c);
        apb(1'b1, TPO_OFF_TRIG, 8'h1f);
        timer_i.fire(1, 1);
        check(pin_out[15:8], 8'h58);
        timer_i.fire(1, 0);
        check(pin_out[15:8], 8'h18);
        timer_i.fire(0, 1);
        check(pin_out[15:8], 8'h1c);
        timer_i.fire(0, 0);
        check(pin_out[15:8], 8'h3c);
        apb(1'b1, TPO_OFF_NXT_B, 8'h00);
        @(posedge clk);
        ce <= 1'b0;
        timer_i.fire(0, 1);
        check({7'h0, pready}, 8'h00);
        check(pin_out[15:8], 8'h3c);
        @(posedge clk);
        ce <= 1'b1;
        timer_i.fire(0, 1);
        check(pin_out[15:8], 8'h30);
        $display("test port b done");
    endtask

    // Reset, then each scenario in turn.
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        pin_in = 16'h0000;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_normal();
        t_nonover();
        t_pins();
        t_portb();
        conclude();
    end
endmodule
